// ===== verilog/smcg_pkg.sv
package smcg_pkg;
    // register map, on the plain register port
    localparam logic [3:0] CORE_CTRL_REG_ADDR        = 4'h0;
    localparam logic [3:0] PERIPH_CLOCK_STOP_REG_ADDR = 4'h1;
    localparam logic [3:0] STATUS_REG_ADDR           = 4'h2;
    localparam logic [3:0] ANALOG_CTRL_REG_ADDR      = 4'h3;
    // core_ctrl_reg fields
    localparam int         SLEEP_ALLOW_BIT   = 5;
    localparam int         SLEEP_KIND_HI     = 4;
    localparam int         SLEEP_KIND_LO     = 3;
    localparam logic [7:0] CORE_CTRL_WMASK   = 8'h7b;
    localparam logic [7:0] CORE_CTRL_RESET   = 8'h00;
    // periph_clock_stop_reg fields
    localparam int         STOP_TIMER_ONE    = 3;
    localparam int         STOP_TIMER_ZERO   = 2;
    localparam int         STOP_SERIAL_UNIT  = 1;
    localparam int         STOP_CONVERTER    = 0;
    localparam logic [7:0] CLOCK_STOP_WMASK  = 8'h0f;
    localparam logic [7:0] CLOCK_STOP_RESET  = 8'h00;
    // analog_ctrl fields
    localparam int         ADC_ENABLE_BIT    = 0;
    localparam int         COMPARATOR_OFF_BIT = 1;
    localparam int         COMP_USES_REF_BIT = 2;
    localparam logic [7:0] ANALOG_CTRL_WMASK = 8'h07;
    localparam logic [7:0] ANALOG_CTRL_RESET = 8'h00;
    // sleep kinds
    localparam logic [1:0] KIND_IDLE         = 2'h0;
    localparam logic [1:0] KIND_NOISE_RED    = 2'h1;
    localparam logic [1:0] KIND_POWER_DOWN   = 2'h2;
    localparam logic [1:0] KIND_STANDBY      = 2'h3;
    // wake source vector positions
    localparam int         WAKE_WIDTH        = 9;
    localparam int         WK_EXT0_LEVEL     = 0;
    localparam int         WK_EXT0_EDGE      = 1;
    localparam int         WK_EXT1_LEVEL     = 2;
    localparam int         WK_EXT1_EDGE      = 3;
    localparam int         WK_PIN_CHANGE     = 4;
    localparam int         WK_SELFWRITE_RDY  = 5;
    localparam int         WK_ADC_DONE       = 6;
    localparam int         WK_WATCHDOG       = 7;
    localparam int         WK_SERIAL_UNIT    = 8;
    // wake timing, in cycles of the 20 MHz clock
    localparam logic [3:0] WAKE_HALT_CYCLES  = 4'h4;
    localparam logic [3:0] STANDBY_CYCLES    = 4'h6;
    localparam logic [3:0] OSC_START_DEFAULT = 4'h8;
    localparam logic [7:0] REF_START_DEFAULT = 8'h14;
endpackage

// ===== verilog/smcg_sleep_ctrl.sv
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/10ps
// Contract
// - sleep only when allowed and instruction executes
// - idle stops cpu and flash clocks
// - noise reduction keeps only adc clock, oscillator
// - power-down stops oscillator and all clocks
// - standby keeps oscillator running, crystal only
// - standby wake resumes after six cycles
// - interrupt wake halts four cycles plus startup
// - sleep never touches register file or sram
// - reset during sleep wakes, restarts at vector
// - idle honours every wake source
// - noise reduction honours a restricted wake set
// - deep sleep ignores edge external interrupts
// - idle or noise entry starts adc conversion
// - clock-stop bit freezes peripheral and registers
// - clearing clock-stop resumes exactly prior state
// - clock-stop matters only in active, idle; the adc bit 0 still gates the converter clock in noise reduction
// - adc stays on; re-enable gives extended conversion
// - deep sleep turns comparator off unless reference
// - input buffers off when io, adc clocks stop
// - reference powered only while a user needs it
// - watchdog and brown-out never gated by sleep
// - sleep-allow bit 5, mode bits 4..3
// - clock-stop bits timer1 3 .. adc 0
module smcg_sleep_ctrl (
    input  wire logic                            clock,
    input  wire logic                            resetn,
    input  wire logic [3:0]                      reg_addr,
    input  wire logic [7:0]                      reg_wdata,
    input  wire logic                            reg_write,
    input  wire logic                            reg_read,
    output logic      [7:0]                      reg_rdata,
    input  wire logic                            sleep_instr,
    input  wire logic                            crystal_clock_sel,
    input  wire logic                            wake_irq_enabled,
    input  wire logic                            wake_reset,
    input  wire logic [smcg_pkg::WAKE_WIDTH-1:0] wake_src,
    input  wire logic                            other_io_irq,
    input  wire logic                            watchdog_enabled,
    input  wire logic                            brownout_enabled,
    input  wire logic [3:0]                      osc_start_cycles,
    output logic                                 clk_cpu_en,
    output logic                                 clk_flash_en,
    output logic                                 clk_io_en,
    output logic                                 clk_adc_en,
    output logic                                 clk_fast_periph_en,
    output logic                                 main_osc_en,
    output logic                                 timer_one_clk_en,
    output logic                                 timer_zero_clk_en,
    output logic                                 serial_unit_clk_en,
    output logic                                 converter_clk_en,
    output logic                                 periph_access_block,
    output logic                                 adc_start_conv,
    output logic                                 adc_extended_next,
    output logic                                 comparator_power,
    output logic                                 vref_power,
    output logic                                 vref_ready,
    output logic                                 input_buffer_disable,
    output logic                                 watchdog_run,
    output logic                                 brownout_run,
    output logic                                 wake_to_vector,
    output logic                                 wake_irq_service
);
    import smcg_pkg::*;

    typedef enum logic [2:0] {SMCG_ACTIVE, SMCG_SLEEP, SMCG_START, SMCG_HALT} smcg_state_e;

    logic        rst_meta_r, rst_sync_r;
    logic        rstn;
    logic [7:0]  core_ctrl_r, clock_stop_r, analog_ctrl_r;
    logic [1:0]  kind_r;
    logic [3:0]  cnt_r;
    logic [7:0]  ref_cnt_r;
    logic        adc_was_on_r;
    logic        ref_was_needed_r;
    logic        sleep_req_q1_r, sleep_req_r;
    logic        rst_wake_q1_r, rst_wake_r;
    logic        irq_en_q1_r, irq_en_r;
    logic        other_q1_r, other_r;
    logic        xtal_q1_r, xtal_r;
    logic [WAKE_WIDTH-1:0] wake_q1_r, wake_r;
    smcg_state_e state_r;
    logic        wake_hit;
    logic        vref_need;
    logic        sleeping;

    // reset released through two flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign rstn = rst_sync_r;

    // external inputs pass two flops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sleep_req_q1_r <= 1'b0;
            sleep_req_r    <= 1'b0;
            rst_wake_q1_r  <= 1'b0;
            rst_wake_r     <= 1'b0;
            irq_en_q1_r    <= 1'b0;
            irq_en_r       <= 1'b0;
            other_q1_r     <= 1'b0;
            other_r        <= 1'b0;
            xtal_q1_r      <= 1'b0;
            xtal_r         <= 1'b0;
            wake_q1_r      <= '0;
            wake_r         <= '0;
        end else begin
            sleep_req_q1_r <= sleep_instr;
            sleep_req_r    <= sleep_req_q1_r;
            rst_wake_q1_r  <= wake_reset;
            rst_wake_r     <= rst_wake_q1_r;
            irq_en_q1_r    <= wake_irq_enabled;
            irq_en_r       <= irq_en_q1_r;
            other_q1_r     <= other_io_irq;
            other_r        <= other_q1_r;
            xtal_q1_r      <= crystal_clock_sel;
            xtal_r         <= xtal_q1_r;
            wake_q1_r      <= wake_src;
            wake_r         <= wake_q1_r;
        end
    end

    // which sources may wake the core in a given sleep kind
    function automatic logic [WAKE_WIDTH:0] smcg_wake_mask(input logic [1:0] kind);
        logic [WAKE_WIDTH:0] m;
        m = '0;
        case (kind)
            KIND_IDLE: begin
                m = '1;
            end
            KIND_NOISE_RED: begin
                m[WK_ADC_DONE]      = 1'b1;
                m[WK_SELFWRITE_RDY] = 1'b1;
                m[WK_EXT0_LEVEL]    = 1'b1;
                m[WK_PIN_CHANGE]    = 1'b1;
                m[WK_WATCHDOG]      = 1'b1;
                m[WK_SERIAL_UNIT]   = 1'b1;
            end
            default: begin
                m[WK_EXT0_LEVEL]    = 1'b1;
                m[WK_EXT1_LEVEL]    = 1'b1;
                m[WK_PIN_CHANGE]    = 1'b1;
                m[WK_WATCHDOG]      = 1'b1;
                m[WK_SERIAL_UNIT]   = 1'b1;
            end
        endcase
        return m;
    endfunction

    assign wake_hit = irq_en_r && (|({other_r, wake_r} & smcg_wake_mask(kind_r)));
    assign sleeping = (state_r != SMCG_ACTIVE);

    // software registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            core_ctrl_r   <= CORE_CTRL_RESET;
            clock_stop_r  <= CLOCK_STOP_RESET;
            analog_ctrl_r <= ANALOG_CTRL_RESET;
        end else if (reg_write) begin
            case (reg_addr)
                CORE_CTRL_REG_ADDR:         core_ctrl_r   <= reg_wdata & CORE_CTRL_WMASK;
                PERIPH_CLOCK_STOP_REG_ADDR: clock_stop_r  <= reg_wdata & CLOCK_STOP_WMASK;
                ANALOG_CTRL_REG_ADDR:       analog_ctrl_r <= reg_wdata & ANALOG_CTRL_WMASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                CORE_CTRL_REG_ADDR:         reg_rdata <= core_ctrl_r;
                PERIPH_CLOCK_STOP_REG_ADDR: reg_rdata <= clock_stop_r;
                ANALOG_CTRL_REG_ADDR:       reg_rdata <= analog_ctrl_r;
                STATUS_REG_ADDR:            reg_rdata <= {3'h0, vref_ready, adc_extended_next, kind_r, sleeping};
                default:                    reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // sleep sequencer; only clock gates change, so register file and sram keep contents
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r          <= SMCG_ACTIVE;
            kind_r           <= KIND_IDLE;
            cnt_r            <= 4'h0;
            wake_to_vector   <= 1'b0;
            wake_irq_service <= 1'b0;
            adc_start_conv   <= 1'b0;
        end else begin
            wake_to_vector   <= 1'b0;
            wake_irq_service <= 1'b0;
            adc_start_conv   <= 1'b0;
            case (state_r)
                SMCG_ACTIVE: begin
                    if (sleep_req_r && core_ctrl_r[SLEEP_ALLOW_BIT]) begin
                        state_r <= SMCG_SLEEP;
                        kind_r  <= core_ctrl_r[SLEEP_KIND_HI:SLEEP_KIND_LO];
                        if (core_ctrl_r[SLEEP_KIND_HI:SLEEP_KIND_LO] == KIND_STANDBY && !xtal_r) begin
                            kind_r <= KIND_POWER_DOWN;
                        end
                        if (!core_ctrl_r[SLEEP_KIND_HI] && analog_ctrl_r[ADC_ENABLE_BIT]) begin
                            adc_start_conv <= 1'b1;
                        end
                    end
                end
                SMCG_SLEEP: begin
                    if (rst_wake_r) begin
                        state_r        <= SMCG_ACTIVE;
                        wake_to_vector <= 1'b1;
                    end else if (wake_hit) begin
                        state_r <= SMCG_START;
                        if (kind_r == KIND_STANDBY) begin
                            cnt_r <= STANDBY_CYCLES;
                        end else if (kind_r == KIND_POWER_DOWN) begin
                            cnt_r <= osc_start_cycles;
                        end else begin
                            cnt_r <= 4'h0;
                        end
                    end
                end
                SMCG_START: begin
                    if (cnt_r <= 4'h1) begin
                        state_r <= SMCG_HALT;
                        cnt_r   <= WAKE_HALT_CYCLES;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                SMCG_HALT: begin
                    if (cnt_r == 4'h1) begin
                        state_r          <= SMCG_ACTIVE;
                        wake_irq_service <= 1'b1;
                    end
                    cnt_r <= cnt_r - 4'h1;
                end
                default: state_r <= SMCG_ACTIVE;
            endcase
        end
    end

    // domain gating per kind
    always_comb begin
        clk_cpu_en         = 1'b1;
        clk_flash_en       = 1'b1;
        clk_io_en          = 1'b1;
        clk_adc_en         = 1'b1;
        clk_fast_periph_en = 1'b1;
        main_osc_en        = 1'b1;
        if (state_r == SMCG_SLEEP || state_r == SMCG_START) begin
            clk_cpu_en   = 1'b0;
            clk_flash_en = 1'b0;
            case (kind_r)
                KIND_IDLE: ;
                KIND_NOISE_RED: begin
                    clk_io_en          = 1'b0;
                    clk_fast_periph_en = 1'b0;
                end
                KIND_STANDBY: begin
                    clk_io_en          = 1'b0;
                    clk_adc_en         = 1'b0;
                    clk_fast_periph_en = 1'b0;
                end
                default: begin
                    clk_io_en          = 1'b0;
                    clk_adc_en         = 1'b0;
                    clk_fast_periph_en = 1'b0;
                    main_osc_en        = (state_r == SMCG_START);
                end
            endcase
        end else if (state_r == SMCG_HALT) begin
            clk_cpu_en   = 1'b0;
            clk_flash_en = 1'b0;
        end
    end

    // per-peripheral gates ride on the io/adc domain gates
    assign timer_one_clk_en    = clk_io_en && !clock_stop_r[STOP_TIMER_ONE];
    assign timer_zero_clk_en   = clk_io_en && !clock_stop_r[STOP_TIMER_ZERO];
    assign serial_unit_clk_en  = clk_io_en && !clock_stop_r[STOP_SERIAL_UNIT];
    assign converter_clk_en    = clk_adc_en && !clock_stop_r[STOP_CONVERTER];
    assign periph_access_block = |clock_stop_r[3:0];

    assign input_buffer_disable = !clk_io_en && !clk_adc_en;
    assign watchdog_run         = watchdog_enabled;
    assign brownout_run         = brownout_enabled;

    assign comparator_power = !analog_ctrl_r[COMPARATOR_OFF_BIT] &&
        (analog_ctrl_r[COMP_USES_REF_BIT] || !(sleeping && kind_r[1]));
    assign vref_need  = brownout_enabled || analog_ctrl_r[ADC_ENABLE_BIT] ||
        (comparator_power && analog_ctrl_r[COMP_USES_REF_BIT]);
    assign vref_power = vref_need;

    // reference start-up count and adc power history
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ref_cnt_r         <= 8'h00;
            ref_was_needed_r  <= 1'b0;
            vref_ready        <= 1'b0;
            adc_was_on_r      <= 1'b0;
            adc_extended_next <= 1'b1;
        end else begin
            ref_was_needed_r <= vref_need;
            if (!vref_need) begin
                ref_cnt_r  <= 8'h00;
                vref_ready <= 1'b0;
            end else if (!ref_was_needed_r) begin
                ref_cnt_r <= REF_START_DEFAULT;
            end else if (ref_cnt_r > 8'h01) begin
                ref_cnt_r <= ref_cnt_r - 8'h01;
            end else begin
                vref_ready <= 1'b1;
            end
            adc_was_on_r <= analog_ctrl_r[ADC_ENABLE_BIT];
            if (analog_ctrl_r[ADC_ENABLE_BIT] && !adc_was_on_r) begin
                adc_extended_next <= 1'b1;
            end else if (adc_start_conv) begin
                adc_extended_next <= 1'b0;
            end
        end
    end

    // assertions
    sequence wake_seen_s;
        state_r == SMCG_SLEEP && !rst_wake_r && wake_hit && kind_r == KIND_STANDBY;
    endsequence

    sleep_entry_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == SMCG_ACTIVE && sleep_req_r && !core_ctrl_r[SLEEP_ALLOW_BIT]) |=> state_r == SMCG_ACTIVE)
        else $error("sleep entered without allow bit");
    idle_gate_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == SMCG_SLEEP && kind_r == KIND_IDLE) |-> (!clk_cpu_en && clk_io_en && main_osc_en))
        else $error("idle gating wrong");
    noise_gate_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == SMCG_SLEEP && kind_r == KIND_NOISE_RED) |-> (!clk_io_en && clk_adc_en && main_osc_en))
        else $error("noise reduction gating wrong");
    powerdown_gate_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == SMCG_SLEEP && kind_r == KIND_POWER_DOWN) |-> (!main_osc_en && !clk_adc_en))
        else $error("power-down left a clock running");
    standby_wake_a: assert property (@(posedge clock) disable iff (!rstn)
        wake_seen_s |=> (state_r == SMCG_START)[*6] ##1 state_r == SMCG_HALT)
        else $error("standby wake not six cycles");
    halt_four_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == SMCG_START && $past(state_r) == SMCG_START && cnt_r == 4'h1) |=>
        (!clk_cpu_en)[*4] ##1 clk_cpu_en && wake_irq_service)
        else $error("wake halt not four cycles");
    reset_wake_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == SMCG_SLEEP && rst_wake_r) |=> (wake_to_vector && state_r == SMCG_ACTIVE))
        else $error("reset did not wake to vector");
    edge_ignored_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == SMCG_SLEEP && kind_r[1] && !rst_wake_r && !wake_r[WK_EXT0_LEVEL] && !wake_r[WK_EXT1_LEVEL]
         && !wake_r[WK_PIN_CHANGE] && !wake_r[WK_WATCHDOG] && !wake_r[WK_SERIAL_UNIT]) |=> state_r == SMCG_SLEEP)
        else $error("deep sleep woke on edge source");
    buffer_off_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_r inside {SMCG_SLEEP, SMCG_START} && kind_r[1]) |->
        (input_buffer_disable && !clk_io_en && !clk_adc_en))
        else $error("input buffers left on");
endmodule

// ===== dv/smcg_core_model.sv
`timescale 1ns/10ps
module smcg_core_model (
    input  wire logic                            clock,
    input  wire logic                            do_sleep,
    input  wire logic [smcg_pkg::WAKE_WIDTH-1:0] raise_src,
    input  wire logic                            drop_src,
    input  wire logic                            wake_irq_service,
    output logic                                 sleep_instr,
    output logic      [smcg_pkg::WAKE_WIDTH-1:0] wake_src
);
    import smcg_pkg::*;
    initial begin
        sleep_instr = 1'b0;
        wake_src    = '0;
    end
    // the core executes the sleep instruction for one cycle when asked
    always @(posedge clock) begin
        sleep_instr <= do_sleep;
    end
    // a raised source keeps its level until the core is serviced or drop_src clears it, not sticky in the device
    always @(posedge clock) begin
        if (drop_src || wake_irq_service) begin
            wake_src <= '0;
        end else begin
            wake_src <= wake_src | raise_src;
        end
    end
endmodule

// ===== dv/test_sleep_mode_clock_gating.sv
`timescale 1ns/10ps
module test_sleep_mode_clock_gating;
    import smcg_pkg::*;
    logic                  clock = 1'b0;
    logic                  resetn = 1'b0;
    logic [3:0]            reg_addr = 4'h0;
    logic [7:0]            reg_wdata = 8'h00;
    logic                  reg_write = 1'b0;
    logic                  reg_read = 1'b0;
    logic                  wake_reset = 1'b0;
    logic                  do_sleep = 1'b0;
    logic                  drop_src = 1'b0;
    logic [WAKE_WIDTH-1:0] raise_src = '0;
    logic                  watchdog_enabled = 1'b1;
    logic                  brownout_enabled = 1'b0;
    logic [3:0]            osc_start_cycles = 4'h9;
    logic [7:0]            reg_rdata;
    logic                  sleep_instr;
    logic [WAKE_WIDTH-1:0] wake_src;
    logic clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, clk_fast_periph_en, main_osc_en, timer_one_clk_en;
    logic timer_zero_clk_en, serial_unit_clk_en, converter_clk_en, periph_access_block, adc_start_conv;
    logic adc_extended_next, comparator_power, vref_power, vref_ready, input_buffer_disable, watchdog_run;
    logic brownout_run, wake_to_vector, wake_irq_service;
    logic [7:0]            exp_q[$];
    logic                  rd_d = 1'b0;
    logic [7:0]            d;
    logic [7:0]            dom;
    int                    num_errors = 0;
    int                    comparisons = 0;
    int                    n_conv = 0;
    int                    conv;
    int                    i;
    int                    k;
    int                    lat[4];
    integer                seed = 32'h3482996e;

    smcg_sleep_ctrl i_dut (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .sleep_instr, .crystal_clock_sel(1'b1), .wake_irq_enabled(1'b1), .wake_reset, .wake_src,
        .other_io_irq(1'b0), .watchdog_enabled, .brownout_enabled, .osc_start_cycles, .clk_cpu_en,
        .clk_flash_en, .clk_io_en, .clk_adc_en, .clk_fast_periph_en, .main_osc_en, .timer_one_clk_en,
        .timer_zero_clk_en, .serial_unit_clk_en, .converter_clk_en, .periph_access_block, .adc_start_conv,
        .adc_extended_next, .comparator_power, .vref_power, .vref_ready, .input_buffer_disable, .watchdog_run,
        .brownout_run, .wake_to_vector, .wake_irq_service);
    smcg_core_model i_core (.clock, .do_sleep, .raise_src, .drop_src, .wake_irq_service, .sleep_instr, .wake_src);

    always #25 clock = ~clock;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_read <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
    endtask
    task automatic pulse_src(input logic [WAKE_WIDTH-1:0] v);
        raise_src <= v;
        @(posedge clock);
        raise_src <= '0;
    endtask
    task automatic sleep_now();
        do_sleep <= 1'b1;
        @(posedge clock);
        do_sleep <= 1'b0;
        @(posedge clock);
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clock) begin
        rd_d <= reg_read;
        if (rd_d && exp_q.size() > 0) check("rdata", reg_rdata, exp_q.pop_front());
        if (adc_start_conv === 1'b1) n_conv++;
    end

    initial begin
        #(50 * 5000);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        watchdog_enabled <= 1'($random(seed));
        brownout_enabled <= 1'($random(seed));
        cyc(2);
        resetn <= 1'b1;
        cyc(3);
        check("vref_start", 8'(vref_power), 8'(brownout_enabled));
        rd(STATUS_REG_ADDR, 8'h08);
        rd(CORE_CTRL_REG_ADDR, CORE_CTRL_RESET);
        rd(PERIPH_CLOCK_STOP_REG_ADDR, CLOCK_STOP_RESET);
        rd(4'hf, 8'h00);
        wr(CORE_CTRL_REG_ADDR, 8'hff);
        rd(CORE_CTRL_REG_ADDR, 8'hff & CORE_CTRL_WMASK);
        d = 8'($random(seed));
        wr(PERIPH_CLOCK_STOP_REG_ADDR, d);
        rd(PERIPH_CLOCK_STOP_REG_ADDR, d & CLOCK_STOP_WMASK);
        dom = {3'h0, periph_access_block, timer_one_clk_en, timer_zero_clk_en, serial_unit_clk_en, converter_clk_en};
        check("clock_stop", dom, {3'h0, |d[3:0], ~d[3:0]});
        wr(PERIPH_CLOCK_STOP_REG_ADDR, 8'h00);
        dom = {3'h0, periph_access_block, timer_one_clk_en, timer_zero_clk_en, serial_unit_clk_en, converter_clk_en};
        check("clock_run", dom, 8'h0f);
        $display("test registers done");
        wr(CORE_CTRL_REG_ADDR, 8'h10);
        sleep_now();
        cyc(6);
        check("not_allowed", 8'(clk_cpu_en), 8'h01);
        wr(ANALOG_CTRL_REG_ADDR, 8'h01);
        cyc(1);
        check("vref_on", 8'(vref_power), 8'h01);
        $display("test sleep allow done");
        for (k = 0; k < 4; k++) begin
            wr(CORE_CTRL_REG_ADDR, 8'(32'h20 | (k << 3)));
            conv = n_conv;
            sleep_now();
            for (i = 0; i < 20 && clk_cpu_en !== 1'b0; i++) @(posedge clock);
            cyc(3);
            dom = {2'b00, clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, clk_fast_periph_en, main_osc_en};
            case (k)
                0: check("idle", dom, 8'h0f);
                1: check("noise", dom, 8'h05);
                2: check("power_down", dom, 8'h00);
                default: check("standby", dom, 8'h01);
            endcase
            check("conversion", 8'(n_conv - conv), 8'(k < 2));
            check("input_buffers", 8'(input_buffer_disable), 8'(k > 1));
            check("comparator", 8'(comparator_power), 8'(k < 2));
            check("watchdog", 8'(watchdog_run), 8'(watchdog_enabled));
            check("brownout", 8'(brownout_run), 8'(brownout_enabled));
            if (k > 0) begin
                pulse_src(WAKE_WIDTH'(1 << WK_EXT0_EDGE));
                cyc(10);
                check("edge_wake", 8'(clk_cpu_en), 8'h00);
                drop_src <= 1'b1;
                @(posedge clock);
                drop_src <= 1'b0;
                cyc(3);
            end
            pulse_src(WAKE_WIDTH'(1 << WK_PIN_CHANGE));
            for (i = 0; i < 60 && wake_irq_service !== 1'b1; i++) @(posedge clock);
            lat[k] = i;
            cyc(1);
            check("resumed", 8'(clk_cpu_en), 8'h01);
            cyc(3);
            $display("test mode %0d done", k);
        end
        check("noise_wake", 8'(lat[1] - lat[0]), 8'h00);
        check("pdown_wake", 8'(lat[2] - lat[0]), 8'(osc_start_cycles - 4'h1));
        check("standby_wake", 8'(lat[3] - lat[0]), 8'(STANDBY_CYCLES - 4'h1));
        wr(CORE_CTRL_REG_ADDR, 8'h30);
        sleep_now();
        cyc(8);
        wake_reset <= 1'b1;
        for (i = 0; i < 40 && wake_to_vector !== 1'b1; i++) @(posedge clock);
        check("vector_seen", 8'(i < 40), 8'h01);
        wake_reset <= 1'b0;
        cyc(2);
        check("vector_run", 8'(clk_cpu_en), 8'h01);
        rd(CORE_CTRL_REG_ADDR, 8'h30);
        rd(STATUS_REG_ADDR, {3'h0, 1'b1, 1'b0, KIND_POWER_DOWN, 1'b0});
        $display("test reset wake done");
        tally_and_finish();
    end
endmodule
